// >>> rtl/serial_port_error_flow.sv
// serial port with receive error coding, discard and flow control
//
// Notes on behaviour
// - error in message drops whole message
// - stream error drops byte and rest
// - ignore setting disregards all receive errors
// - code 0 after clean operation
// - parity mismatch records code 1
// - lost character before acceptance records code 2; here a character is only lost with the buffer full, so code 3 is recorded
// - buffer overflow records code 3
// - missing stop bit records code 4
// - throttle sender before buffer overflows
// - request-to-send high while data accepted
// - no transmit start while clear-to-send low
// - data-terminal-ready high while powered
// - transmit on txd, receive on rxd
// - drop request-to-send near full, hysteresis
// - transmit pauses and resumes with clear-to-send
// - software flow sends 19 then 17
// - received stop character suspends transmit
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module serial_port_error_flow #(
  parameter int DEPTH   = 16,
  parameter int HI_MARK = 12,
  parameter int LO_MARK = 4
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // serial link
  input  wire logic        rxd,
  output logic             txd,
  output logic             rts,
  input  wire logic        cts,
  output logic             dtr
);
  import serial_err_pkg::*;

  localparam int AW = $clog2(DEPTH) + 1;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  cfg_t             cfg_q;
  logic [BIT_W-1:0] baud_q;
  logic             stream_q;
  err_code_t        code_q;
  logic             wr_ph_q;
  logic [7:0]       wa_q;
  logic [31:0]      hrdata_q;
  logic [7:0]       mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    cm_q;
  logic [AW-1:0]    rd_q;
  rx_char_t         hold_q;
  logic             hold_v_q;
  logic             drop_q;
  logic             sdisc_q;
  logic             rts_q;
  logic             xoff_pend_q;
  logic             xon_pend_q;
  logic             tx_paused_q;
  logic [7:0]       txbuf_q;
  logic             txbuf_v_q;
  logic [31:0]      rdata_d;

  // ------------------------------------------------------------------
  // named wires
  // ------------------------------------------------------------------
  wire logic        addr_ok;
  wire logic        rd_take;
  wire logic [7:0]  ra;
  wire logic        ctrl_wr;
  wire logic        baud_wr;
  wire logic        mode_wr;
  wire logic        data_wr;
  wire logic        rx_v;
  rx_char_t         rx_c;
  wire logic        tx_busy;
  wire logic        tx_start;
  wire logic [7:0]  tx_byte;
  wire logic [AW-1:0] count;
  wire logic        full;
  wire logic        pop_ok;
  wire logic        pop;
  wire logic        hold_err;
  wire logic        acc;
  wire logic        lost;
  wire logic        is_term;
  wire logic        is_flow;
  wire logic        bad;
  wire logic        store;
  wire logic        commit;
  wire logic        end_drop;
  err_code_t        code_d;
  wire logic        hi_reach;
  wire logic        lo_reach;
  wire logic        rts_fall;
  wire logic        rts_rise;

  // ------------------------------------------------------------------
  // bus slave: zero wait states, reads sampled in the address phase
  // ------------------------------------------------------------------
  assign addr_ok   = hsel & htrans[1] & hready;
  assign rd_take   = addr_ok & ~hwrite;
  assign ra        = haddr[7:0];
  assign ctrl_wr   = wr_ph_q & (wa_q == A_CTRL);
  assign baud_wr   = wr_ph_q & (wa_q == A_BAUD);
  assign mode_wr   = wr_ph_q & (wa_q == A_MODE);
  assign data_wr   = wr_ph_q & (wa_q == A_DATA);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_comb begin
    case (ra)
      A_CTRL:  rdata_d = 32'(cfg_q);
      A_BAUD:  rdata_d = 32'(baud_q);
      A_MODE:  rdata_d = 32'(stream_q);
      A_ERR:   rdata_d = 32'(code_q);
      A_DATA:  rdata_d = 32'({pop_ok, mem_q[rd_q[AW-2:0]]});
      A_STAT:  rdata_d = 32'({cts, rts_q, tx_paused_q, txbuf_v_q,
                              tx_busy, drop_q, sdisc_q, count});
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ph_q  <= 1'b0;
      wa_q     <= '0;
      hrdata_q <= '0;
    end else begin
      wr_ph_q <= addr_ok & hwrite;
      if (addr_ok) wa_q <= ra;
      if (rd_take) hrdata_q <= rdata_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q    <= '0;
      baud_q   <= BAUD_RST;
      stream_q <= 1'b0;
    end else begin
      if (ctrl_wr) cfg_q <= cfg_t'(hwdata[CTRL_W-1:0]);
      if (baud_wr) baud_q <= hwdata[BIT_W-1:0];
      if (mode_wr) stream_q <= hwdata[MODE_STREAM];
    end
  end

  // ------------------------------------------------------------------
  // line engines
  // ------------------------------------------------------------------
  serial_rx u_rx (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .cfg      (cfg_q),
    .bit_div  (baud_q),
    .rxd      (rxd),
    .rx_valid (rx_v),
    .rx_char  (rx_c)
  );

  serial_tx u_tx (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .cfg     (cfg_q),
    .bit_div (baud_q),
    .start   (tx_start),
    .data    (tx_byte),
    .busy    (tx_busy),
    .txd     (txd)
  );

  // ------------------------------------------------------------------
  // receive decisions: one character leaves the holding slot at a time
  // ------------------------------------------------------------------
  assign count    = wr_q - rd_q;
  assign full     = (count == AW'(DEPTH));
  assign pop_ok   = (rd_q != cm_q);
  assign pop      = rd_take & (ra == A_DATA) & pop_ok;
  assign hold_err = (hold_q.parity_err | hold_q.frame_err) &
                    ~cfg_q.ignore_err;
  assign acc      = hold_v_q & ~full;
  // a second character while the slot is still occupied and the buffer is full is lost
  assign lost     = rx_v & hold_v_q & ~acc;
  assign is_term  = (hold_q.data == CR_CHAR) | (hold_q.data == LF_CHAR);
  assign is_flow  = cfg_q.xon_en & ~hold_err &
                    ((hold_q.data == XON_CHAR) | (hold_q.data == XOFF_CHAR));
  assign bad      = (acc & hold_err) | (lost & ~cfg_q.ignore_err);
  // a mode write wins over a store in the same cycle
  assign store    = acc & ~hold_err & ~is_flow & ~mode_wr &
                    (stream_q ? ~sdisc_q : ~drop_q);
  assign commit   = store & (stream_q | is_term);
  assign end_drop = acc & ~hold_err & ~is_flow & ~stream_q & drop_q &
                    is_term;
  assign code_d   = lost ? (full ? buffer_overflow_error_code
                                 : overrun_error_code)
                  : hold_q.frame_err ? framing_error_code
                  : parity_error_code;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_q   <= '0;
      hold_v_q <= 1'b0;
      code_q   <= no_serial_error_code;
    end else begin
      if (rx_v & (~hold_v_q | acc)) hold_q <= rx_c;
      hold_v_q <= (rx_v & (~hold_v_q | acc)) | (hold_v_q & ~acc);
      if (bad) code_q <= code_d;
      else if (commit) code_q <= no_serial_error_code;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (store) mem_q[wr_q[AW-2:0]] <= hold_q.data;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q    <= '0;
      cm_q    <= '0;
      rd_q    <= '0;
      drop_q  <= 1'b0;
      sdisc_q <= 1'b0;
    end else begin
      if (store) wr_q <= wr_q + 1'b1;
      if (commit) cm_q <= wr_q + 1'b1;
      // rewind to the last whole message on an error or mode change
      if ((bad & ~stream_q) | mode_wr) wr_q <= cm_q;
      if (pop) rd_q <= rd_q + 1'b1;
      if (end_drop | mode_wr) drop_q <= 1'b0;
      if (bad & ~stream_q) drop_q <= 1'b1;
      if (mode_wr) sdisc_q <= 1'b0;
      if (bad & stream_q) sdisc_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // flow control with hysteresis between the two marks
  // ------------------------------------------------------------------
  assign hi_reach = (count >= AW'(HI_MARK));
  assign lo_reach = (count <= AW'(LO_MARK));
  assign rts_fall = rts_q & hi_reach;
  assign rts_rise = ~rts_q & lo_reach;
  assign rts      = rts_q;
  assign dtr      = 1'b1;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rts_q       <= 1'b1;
      xoff_pend_q <= 1'b0;
      xon_pend_q  <= 1'b0;
      tx_paused_q <= 1'b0;
    end else begin
      if (rts_fall) rts_q <= 1'b0;
      else if (rts_rise) rts_q <= 1'b1;
      if (tx_start | rts_rise) xoff_pend_q <= 1'b0;
      if (rts_fall & cfg_q.xon_en) xoff_pend_q <= 1'b1;
      if ((tx_start & ~xoff_pend_q) | rts_fall) xon_pend_q <= 1'b0;
      if (rts_rise & cfg_q.xon_en) xon_pend_q <= 1'b1;
      if (~cfg_q.xon_en) tx_paused_q <= 1'b0;
      else if (acc & is_flow)
        tx_paused_q <= (hold_q.data == XOFF_CHAR);
    end
  end

  // ------------------------------------------------------------------
  // transmit arbitration: flow characters go before host data
  // ------------------------------------------------------------------
  // a started character always completes; the pause acts between
  // characters, which keeps the line free of cut-off frames
  assign tx_start = ~tx_busy & cts &
                    (xoff_pend_q | xon_pend_q | (txbuf_v_q & ~tx_paused_q));
  assign tx_byte  = xoff_pend_q ? XOFF_CHAR :
                    xon_pend_q  ? XON_CHAR  : txbuf_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txbuf_q   <= '0;
      txbuf_v_q <= 1'b0;
    end else begin
      if (tx_start & ~xoff_pend_q & ~xon_pend_q) txbuf_v_q <= 1'b0;
      if (data_wr & ~txbuf_v_q) begin
        txbuf_q   <= hwdata[7:0];
        txbuf_v_q <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/serial_err_pkg.sv
// constants, types and helpers shared by the serial error-flow port
package serial_err_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BAUD = 8'h04;
  localparam logic [7:0] A_MODE = 8'h08;
  localparam logic [7:0] A_ERR  = 8'h0C;
  localparam logic [7:0] A_DATA = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;

  // ------------------------------------------------------------------
  // field layout, reset values and timing
  // ------------------------------------------------------------------
  localparam int         CTRL_W      = 5;
  localparam int         BIT_W       = 16;
  localparam int         MODE_STREAM = 0;
  localparam int         TX_FRAME_W  = 11;
  localparam logic [3:0] TX_LAST_BIT = 4'hA;
  localparam logic [2:0] LAST_BIT7   = 3'h6;
  localparam logic [2:0] LAST_BIT8   = 3'h7;
  localparam int         CLK_MHZ     = 125;
  localparam int         BAUD_RATE   = 115200;
  // bit period in cycles minus one
  localparam logic [BIT_W-1:0] BAUD_RST =
    BIT_W'(CLK_MHZ * 1000000 / BAUD_RATE - 1);

  // ------------------------------------------------------------------
  // special characters
  // ------------------------------------------------------------------
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  localparam logic [7:0] XON_CHAR  = 8'h11;
  localparam logic [7:0] CR_CHAR   = 8'h0D;
  localparam logic [7:0] LF_CHAR   = 8'h0A;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    no_serial_error_code       = 3'h0,
    parity_error_code          = 3'h1,
    overrun_error_code         = 3'h2,
    buffer_overflow_error_code = 3'h3,
    framing_error_code         = 3'h4
  } err_code_t;

  typedef struct packed {
    logic ignore_err;
    logic xon_en;
    logic parity_odd;
    logic parity_en;
    logic seven_bits;
  } cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       parity_err;
    logic       frame_err;
  } rx_char_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'b0_0001,
    RX_START = 5'b0_0010,
    RX_DATA  = 5'b0_0100,
    RX_PAR   = 5'b0_1000,
    RX_STOP  = 5'b1_0000
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

  // parity bit that goes with a character
  function automatic logic char_parity(input logic [7:0] d,
                                       input logic       seven,
                                       input logic       odd);
    return (^(seven ? {1'b0, d[6:0]} : d)) ^ odd;
  endfunction

endpackage

// >>> rtl/serial_rx.sv
// asynchronous serial receiver with parity and stop-bit checks
`timescale 1ns/100ps
`default_nettype none
module serial_rx (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  // settings
  input  wire serial_err_pkg::cfg_t         cfg,
  input  wire logic [serial_err_pkg::BIT_W-1:0] bit_div,
  // line and result
  input  wire logic                         rxd,
  output logic                              rx_valid,
  output serial_err_pkg::rx_char_t          rx_char
);
  import serial_err_pkg::*;

  rx_state_t        st_q;
  logic [BIT_W-1:0] cnt_q;
  logic [2:0]       bit_q;
  logic [7:0]       sh_q;
  logic             par_q;
  wire logic        tick;
  wire logic [2:0]  last_bit;
  wire logic [7:0]  data;

  assign tick     = (cnt_q == '0);
  assign last_bit = cfg.seven_bits ? LAST_BIT7 : LAST_BIT8;
  // seven-bit characters end up in the top of the shifter
  assign data     = cfg.seven_bits ? {1'b0, sh_q[7:1]} : sh_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q     <= RX_IDLE;
      cnt_q    <= '0;
      bit_q    <= '0;
      sh_q     <= '0;
      par_q    <= 1'b0;
      rx_valid <= 1'b0;
      rx_char  <= '0;
    end else begin
      rx_valid <= 1'b0;
      if (!tick) cnt_q <= cnt_q - 1'b1;
      case (st_q)
        RX_IDLE: if (!rxd) begin
          st_q  <= RX_START;
          cnt_q <= bit_div >> 1;
        end
        RX_START: if (tick) begin
          cnt_q <= bit_div;
          bit_q <= '0;
          st_q  <= rxd ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (tick) begin
          sh_q  <= {rxd, sh_q[7:1]};
          cnt_q <= bit_div;
          bit_q <= bit_q + 1'b1;
          if (bit_q == last_bit) st_q <= cfg.parity_en ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (tick) begin
          par_q <= rxd;
          cnt_q <= bit_div;
          st_q  <= RX_STOP;
        end
        RX_STOP: if (tick) begin
          rx_valid           <= 1'b1;
          rx_char.data       <= data;
          rx_char.parity_err <= cfg.parity_en &
            (char_parity(data, cfg.seven_bits, cfg.parity_odd) != par_q);
          rx_char.frame_err  <= !rxd;
          st_q               <= RX_IDLE;
        end
        default: st_q <= RX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> rtl/serial_tx.sv
// asynchronous serial transmitter, one character per start pulse
`timescale 1ns/100ps
`default_nettype none
module serial_tx (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  // settings
  input  wire serial_err_pkg::cfg_t         cfg,
  input  wire logic [serial_err_pkg::BIT_W-1:0] bit_div,
  // character in
  input  wire logic                         start,
  input  wire logic [7:0]                   data,
  output logic                              busy,
  // line
  output logic                              txd
);
  import serial_err_pkg::*;

  tx_state_t             st_q;
  logic [TX_FRAME_W-1:0] frame_q;
  logic [3:0]            nbit_q;
  logic [BIT_W-1:0]      cnt_q;
  wire logic             pbit;
  wire logic [TX_FRAME_W-1:0] frame;

  // without parity the parity slot becomes an extra stop bit
  assign pbit  = cfg.parity_en ?
                 char_parity(data, cfg.seven_bits, cfg.parity_odd) : 1'b1;
  assign frame = cfg.seven_bits ? {2'b11, pbit, data[6:0], 1'b0}
                                : {1'b1, pbit, data, 1'b0};
  assign busy  = (st_q != TX_IDLE);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= TX_IDLE;
      frame_q <= '1;
      nbit_q  <= '0;
      cnt_q   <= '0;
      txd     <= 1'b1;
    end else begin
      case (st_q)
        TX_IDLE: if (start) begin
          txd     <= frame[0];
          frame_q <= {1'b1, frame[TX_FRAME_W-1:1]};
          nbit_q  <= TX_LAST_BIT;
          cnt_q   <= bit_div;
          st_q    <= TX_SHIFT;
        end
        TX_SHIFT: if (cnt_q != '0) begin
          cnt_q <= cnt_q - 1'b1;
        end else if (nbit_q == '0) begin
          st_q <= TX_IDLE;
        end else begin
          txd     <= frame_q[0];
          frame_q <= {1'b1, frame_q[TX_FRAME_W-1:1]};
          nbit_q  <= nbit_q - 1'b1;
          cnt_q   <= bit_div;
        end
        default: st_q <= TX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> bench/serial_port_error_flow_assertions.sv
// port checker for the serial error-flow port
`timescale 1ns/100ps
`default_nettype none
module serial_port_error_flow_chk #(
  parameter int BIT_CYC = 8
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // link
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        rts,
  input wire logic        cts,
  input wire logic        dtr
);
  // ------
  // frame position and receive-line age
  // ------
  logic        txd_q;
  logic [11:0] fc_q;
  logic [11:0] age_q;
  wire         tx_start = (fc_q == 12'h000) && txd_q && !txd;
  wire         rd_req   = hsel && htrans[1] && hready && !hwrite;
  wire  [11:0] fc_d     = (fc_q != 12'h000) ? fc_q - 12'h001 :
                          (tx_start ? 12'(11 * BIT_CYC - 1) : 12'h000);
  // age saturates so long idle spells never wrap back to small values
  wire  [11:0] age_d    = rxd ? age_q + {11'h000, ~&age_q} : 12'h000;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txd_q <= 1'b1;
      fc_q  <= 12'h000;
      age_q <= 12'hFFF;
    end else begin
      txd_q <= txd;
      fc_q  <= fc_d;
      age_q <= age_d;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // ------
  // properties
  // ------
  a_dtr_on: assert property (dtr)
    else $error("dtr low while powered");
  a_reset_out: assert property ($rose(resetn) |-> rts && txd && dtr)
    else $error("link outputs wrong leaving reset");
  a_cts_gate: assert property (
      tx_start |-> $past(cts))
    else $error("frame started with clear-to-send low");
  a_start_low: assert property (
      fc_q >= 12'(10 * BIT_CYC + 1) |-> !txd)
    else $error("start bit too short");
  a_stop_high: assert property (
      fc_q != 12'h000 && fc_q <= 12'(BIT_CYC) |-> txd)
    else $error("stop bit not high");
  a_rts_cause: assert property (
      $fell(rts) |-> age_q < 12'(12 * BIT_CYC))
    else $error("rts dropped with no character arriving");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_rdata_hold: assert property (!$past(rd_req) |-> $stable(hrdata))
    else $error("read data moved without a read");
endmodule

bind serial_port_error_flow serial_port_error_flow_chk #(.BIT_CYC(8)) chk_u (
  .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .rxd(rxd), .txd(txd), .rts(rts),
  .cts(cts), .dtr(dtr)
);
`default_nettype wire

// >>> bench/serial_host.sv
// serial host model: drives the receive line, decodes the transmit line
`timescale 1ns/100ps
`default_nettype none
module serial_host #(
  parameter int BITC = 8
) (
  // clock
  input  wire logic ref_clk,
  // line
  input  wire logic txd,
  output var logic  rxd
);
  logic [7:0] got;
  logic [7:0] rx_byte;
  int         rx_cnt;
  initial rxd = 1'b1;
  task automatic put(input logic v);
    @(posedge ref_clk);
    rxd <= v;
    repeat (BITC - 1) @(posedge ref_clk);
  endtask
  // bad parity or stop bit only when the caller asks for it
  task automatic send(input logic [7:0] d, input int nb, input logic pen,
                      input logic p, input logic stop);
    put(1'b0);
    for (int i = 0; i < nb; i++) begin
      put(d[i]);
    end
    if (pen) put(p);
    put(stop);
    put(1'b1);
    put(1'b1);
  endtask
  // ------
  // receiver: eight data bits, sampled mid-bit
  // ------
  initial begin
    rx_cnt = 0;
    rx_byte = 8'h00;
    forever begin
      @(negedge txd);
      repeat (BITC / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BITC) @(posedge ref_clk);
        got[i] = txd;
      end
      rx_byte = got;
      rx_cnt++;
      repeat (BITC * 2) @(posedge ref_clk);
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the serial error-flow port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import serial_err_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [3:0] nb;
    logic       pflip;
    logic       stop;
    logic [7:0] d;
    logic [2:0] err;
    logic [8:0] dat;
  } row_t;
  localparam row_t ROWS [6] = '{
    '{8'h00, 4'h8, 1'b0, 1'b1, 8'h41, 3'h0, 9'h141},
    '{8'h02, 4'h8, 1'b1, 1'b1, 8'h52, 3'h1, 9'h000},
    '{8'h00, 4'h8, 1'b0, 1'b0, 8'h63, 3'h4, 9'h000},
    '{8'h12, 4'h8, 1'b1, 1'b1, 8'h74, 3'h0, 9'h174},
    '{8'h07, 4'h7, 1'b0, 1'b1, 8'h35, 3'h0, 9'h135},
    '{8'h07, 4'h7, 1'b1, 1'b1, 8'h26, 3'h1, 9'h000}};
  logic        ref_clk, resetn, hsel, hwrite, cts, par;
  logic        hreadyout, hresp, txd, rts, dtr, rxd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  row_t        r;
  int          bad_count, samples_checked, cycles, n;
  serial_port_error_flow dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .rxd(rxd), .txd(txd), .rts(rts), .cts(cts), .dtr(dtr));
  serial_host #(.BITC(8)) host_u (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;
  // ------
  // checking and bus tasks
  // ------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask
  // an empty read only promises the valid bit
  task automatic rdd(input logic [8:0] e);
    bus(1'b0, A_DATA, 32'h0000_0000);
    check(32'({rd[8], rd[7:0] & {8{e[8]}}}), 32'(e));
  endtask
  task automatic tx8(input logic [7:0] d, input logic stop);
    host_u.send(d, 8, 1'b0, 1'b0, stop);
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // ------
  // main sequence
  // ------
  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    cts = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge ref_clk);
    check(32'({rts, txd, dtr}), 32'h0000_0007);
    resetn <= 1'b1;
    rdc(A_CTRL, 32'h0000_0000);
    rdc(A_BAUD, 32'h0000_043C);
    rdc(A_MODE, 32'h0000_0000);
    rdc(A_ERR, 32'h0000_0000);
    rdc(8'h18, 32'h0000_0000);
    wr(A_BAUD, 32'h0000_0007);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      wr(A_CTRL, {24'h00_0000, r.ctrl});
      wr(A_MODE, 32'h0000_0001);
      par = (^(r.d & (r.nb == 4'h7 ? 8'h7F : 8'hFF))) ^ r.ctrl[2] ^ r.pflip;
      host_u.send(r.d, int'(r.nb), r.ctrl[1], par, r.stop);
      rdc(A_ERR, 32'(r.err));
      rdd(r.dat);
    end
    // a stream stays shut after an error until the mode is rewritten
    wr(A_CTRL, 32'h0000_0000);
    wr(A_MODE, 32'h0000_0001);
    tx8(8'h22, 1'b0);
    tx8(8'h33, 1'b1);
    rdd(9'h000);
    bus(1'b0, A_STAT, 32'h0000_0000);
    check(32'(rd[5]), 32'h0000_0001);
    wr(A_MODE, 32'h0000_0001);
    tx8(8'h44, 1'b1);
    rdd(9'h144);
    wr(A_MODE, 32'h0000_0000);
    tx8(8'h41, 1'b1);
    tx8(8'h42, 1'b0);
    tx8(CR_CHAR, 1'b1);
    rdc(A_ERR, 32'h0000_0004);
    rdd(9'h000);
    tx8(8'h43, 1'b1);
    tx8(LF_CHAR, 1'b1);
    rdd(9'h143);
    rdd({1'b1, LF_CHAR});
    rdc(A_ERR, 32'h0000_0000);
    // host ignores flow control here, so the buffer overflows
    wr(A_CTRL, 32'h0000_0008);
    wr(A_MODE, 32'h0000_0001);
    for (int i = 0; i < 18; i++) begin
      tx8(8'h30 + 8'(i), 1'b1);
      if (i == 10) check(32'(rts), 32'h0000_0001);
      if (i == 11) check(32'(rts), 32'h0000_0000);
    end
    rdc(A_ERR, 32'h0000_0003);
    check(32'(host_u.rx_byte), 32'(XOFF_CHAR));
    n = 0;
    while (n < 20 && rts !== 1'b1) begin
      bus(1'b0, A_DATA, 32'h0000_0000);
      n++;
    end
    check(32'(rts), 32'h0000_0001);
    check(32'(n >= 12), 32'h0000_0001);
    repeat (200) @(posedge ref_clk);
    check(32'(host_u.rx_byte), 32'(XON_CHAR));
    n = host_u.rx_cnt;
    cts <= 1'b0;
    wr(A_DATA, 32'h0000_005A);
    repeat (40) @(posedge ref_clk);
    check(32'(host_u.rx_cnt - n), 32'h0000_0000);
    cts <= 1'b1;
    repeat (150) @(posedge ref_clk);
    check(32'(host_u.rx_byte), 32'h0000_005A);
    tx8(XOFF_CHAR, 1'b1);
    bus(1'b0, A_STAT, 32'h0000_0000);
    check(32'(rd[9]), 32'h0000_0001);
    wr(A_DATA, 32'h0000_006B);
    repeat (150) @(posedge ref_clk);
    check(32'(host_u.rx_byte), 32'h0000_005A);
    tx8(XON_CHAR, 1'b1);
    repeat (150) @(posedge ref_clk);
    check(32'(host_u.rx_byte), 32'h0000_006B);
    stop_test();
  end
endmodule
`default_nettype wire
